// ### hdl/dsp_defs.svh
`ifndef DSP_DEFS_SVH
`define DSP_DEFS_SVH
// upper six bits of the two-wire device address
`define DSP_ADDR_HI 6'h34
`define DSP_DIR_WR 1'b0
`define DSP_DIR_RD 1'b1
// control byte that holds the two-wire port disable bit
`define DSP_CTRL_IDX 7'h6A
`define DSP_IFDIS_BIT 4
`define DSP_FIFO_DEPTH 8
// clock rates in kHz
`define DSP_CORE_KHZ 200000
`define DSP_I2C_MAX_KHZ 400
`define DSP_SPI_MAX_KHZ 8000
// least quarter and half bus periods, rounded up to core cycles
`define DSP_I2C_QTR \
  ((`DSP_CORE_KHZ + 4 * `DSP_I2C_MAX_KHZ - 1) / (4 * `DSP_I2C_MAX_KHZ))
`define DSP_SPI_HALF \
  ((`DSP_CORE_KHZ + 2 * `DSP_SPI_MAX_KHZ - 1) / (2 * `DSP_SPI_MAX_KHZ))
`endif

// ### hdl/dsp_pkg.sv
package dsp_pkg;
  typedef logic [6:0] dsp_idx_t;
  typedef logic [7:0] dsp_byte_t;
  typedef enum logic [5:0] {
    DI_IDLE = 6'h01,
    DI_ADDR = 6'h02,
    DI_ACK = 6'h04,
    DI_RX = 6'h08,
    DI_TX = 6'h10,
    DI_MACK = 6'h20
  } dsp_dev_st_e;
  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_START = 5'h02,
    H_BYTE = 5'h04,
    H_STOP = 5'h08,
    H_SPI = 5'h10
  } dsp_host_st_e;
  typedef enum logic [4:0] {
    SG_ADDRW = 5'h01,
    SG_IDX = 5'h02,
    SG_DATA = 5'h04,
    SG_ADDRR = 5'h08,
    SG_RDATA = 5'h10
  } dsp_stage_e;
endpackage : dsp_pkg

// ### hdl/dsp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dsp_link_if;
  // open-drain clock and data lines, low enable pulls low
  logic host_clk_oe_n;
  logic dev_clk_oe_n;
  logic host_dat_oe_n;
  logic dev_dat_oe_n;
  // spi select and serial output shared with the address strap
  logic cs_n;
  logic sdo_o;
  logic sdo_oe_n;
  logic addr_strap;
  logic clk_line;
  logic dat_line;
  logic sdo_line;
  assign clk_line = host_clk_oe_n & dev_clk_oe_n;
  assign dat_line = host_dat_oe_n & dev_dat_oe_n;
  assign sdo_line = sdo_oe_n ? addr_strap : sdo_o;
  modport dev (
    input clk_line, dat_line, cs_n, sdo_line,
    output dev_clk_oe_n, dev_dat_oe_n, sdo_o, sdo_oe_n
  );
  modport host (
    input clk_line, dat_line, sdo_line,
    output host_clk_oe_n, host_dat_oe_n, cs_n
  );
endinterface : dsp_link_if
`default_nettype wire

// ### hdl/dsp_dev_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsp_defs.svh"

// ------------------------------------------------------------
// write buffer
// ------------------------------------------------------------
module dsp_fifo #(
  parameter int W = 15,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  logic do_wr;
  logic do_rd;

  function automatic logic [AW-1:0] nxt_ptr(input logic [AW-1:0] p);
    nxt_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : nxt_ptr

  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem[rp_ff];
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;

  // storage needs no reset, valid words are tracked by the count
  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem[wp_ff] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (do_wr) begin
        wp_ff <= nxt_ptr(wp_ff);
      end
      if (do_rd) begin
        rp_ff <= nxt_ptr(rp_ff);
      end
      cnt_ff <= cnt_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule : dsp_fifo

// ------------------------------------------------------------
// device end
// ------------------------------------------------------------
module dsp_dev_end #(
  parameter int DEPTH = `DSP_FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // link pins
  dsp_link_if.dev link,
  // register writes toward the core
  output logic wr_valid,
  output dsp_pkg::dsp_idx_t wr_idx,
  output dsp_pkg::dsp_byte_t wr_data,
  input wire logic wr_ready,
  // register reads from the core
  output dsp_pkg::dsp_idx_t rd_idx,
  input wire dsp_pkg::dsp_byte_t rd_data,
  output logic rd_take,
  // status
  output logic two_wire_port_disable
);
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic scl_q_ff;
  logic sda_q_ff;
  logic s_scl, s_sda, s_csn, s_sel;
  logic scl_rise, scl_fall, start, stop, i_en;
  dsp_pkg::dsp_dev_st_e i_st_ff;
  logic [3:0] i_cnt_ff;
  dsp_pkg::dsp_byte_t i_rx_ff;
  dsp_pkg::dsp_byte_t i_tx_ff;
  dsp_pkg::dsp_idx_t i_idx_ff;
  logic i_rw_ff, i_first_ff, i_sda_ff, i_scl_ff;
  logic i_byte_end, i_push, i_load, addr_hit;
  logic [2:0] s_cnt_ff;
  dsp_pkg::dsp_byte_t s_rx_ff;
  dsp_pkg::dsp_byte_t s_tx_ff;
  dsp_pkg::dsp_idx_t s_idx_ff;
  logic s_rw_ff, s_first_ff, s_so_ff, s_oe_n_ff;
  logic s_push, s_load;
  logic ifdis_ff;
  logic f_valid, f_ready;
  logic [14:0] f_data;

  function automatic dsp_pkg::dsp_idx_t idx_inc(input dsp_pkg::dsp_idx_t i);
    idx_inc = i + 7'h01;
  endfunction : idx_inc

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_ff <= 4'hF;
      sync2_ff <= 4'hF;
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      sync1_ff <= {link.sdo_line, link.cs_n, link.dat_line, link.clk_line};
      sync2_ff <= sync1_ff;
      scl_q_ff <= sync2_ff[0];
      sda_q_ff <= sync2_ff[1];
    end
  end
  assign s_scl = sync2_ff[0];
  assign s_sda = sync2_ff[1];
  assign s_csn = sync2_ff[2];
  assign s_sel = sync2_ff[3];
  assign scl_rise = s_scl & ~scl_q_ff;
  assign scl_fall = ~s_scl & scl_q_ff;
  // a selected spi frame, or the disable bit once idle, keeps two-wire
  // off; waiting for idle lets the byte that set the bit still be acked
  assign i_en = s_csn & ~(ifdis_ff & (i_st_ff == dsp_pkg::DI_IDLE));
  assign start = i_en & s_scl & scl_q_ff & sda_q_ff & ~s_sda;
  assign stop = i_en & s_scl & scl_q_ff & ~sda_q_ff & s_sda;

  // ------------------------------------------------------------
  // two-wire slave
  // ------------------------------------------------------------
  assign addr_hit = (i_rx_ff[7:1] == {`DSP_ADDR_HI, s_sel});
  // stretching keeps the byte end pending until space frees up
  assign i_byte_end = (i_cnt_ff == 4'h8) & (scl_fall | ~i_scl_ff);
  assign i_push = i_en & ~start & ~stop & (i_st_ff == dsp_pkg::DI_RX)
    & i_byte_end & ~i_first_ff;
  assign i_load = i_en & ~start & ~stop & (i_st_ff == dsp_pkg::DI_ACK)
    & scl_fall & i_rw_ff;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      i_st_ff <= dsp_pkg::DI_IDLE;
      i_cnt_ff <= 4'h0;
      i_rx_ff <= 8'h00;
      i_tx_ff <= 8'h00;
      i_idx_ff <= 7'h00;
      i_rw_ff <= 1'b0;
      i_first_ff <= 1'b0;
      i_sda_ff <= 1'b1;
      i_scl_ff <= 1'b1;
    end else if (!i_en || stop) begin
      i_st_ff <= dsp_pkg::DI_IDLE;
      i_sda_ff <= 1'b1;
      i_scl_ff <= 1'b1;
    end else if (start) begin
      i_st_ff <= dsp_pkg::DI_ADDR;
      i_cnt_ff <= 4'h0;
      i_sda_ff <= 1'b1;
      i_scl_ff <= 1'b1;
    end else begin
      case (i_st_ff)
        dsp_pkg::DI_ADDR, dsp_pkg::DI_RX: begin
          if (scl_rise && i_cnt_ff != 4'h8) begin
            i_rx_ff <= {i_rx_ff[6:0], s_sda};
            i_cnt_ff <= i_cnt_ff + 4'h1;
          end
          if (i_byte_end) begin
            if (i_st_ff == dsp_pkg::DI_ADDR) begin
              if (addr_hit) begin
                i_sda_ff <= 1'b0;
                i_rw_ff <= i_rx_ff[0];
                i_first_ff <= 1'b1;
                i_st_ff <= dsp_pkg::DI_ACK;
              end else begin
                i_st_ff <= dsp_pkg::DI_IDLE;
              end
            end else if (i_first_ff) begin
              i_idx_ff <= i_rx_ff[6:0];
              i_first_ff <= 1'b0;
              i_sda_ff <= 1'b0;
              i_st_ff <= dsp_pkg::DI_ACK;
            end else if (f_ready) begin
              i_idx_ff <= idx_inc(i_idx_ff);
              i_sda_ff <= 1'b0;
              i_st_ff <= dsp_pkg::DI_ACK;
            end else begin
              i_scl_ff <= 1'b0;
            end
          end
        end
        dsp_pkg::DI_ACK: begin
          // a stretch ends one cycle after the ack is set up, never with it
          i_scl_ff <= 1'b1;
          // all data moves just after the clock falls
          if (scl_fall) begin
            if (i_rw_ff) begin
              i_sda_ff <= rd_data[7];
              i_tx_ff <= {rd_data[6:0], 1'b0};
              i_idx_ff <= idx_inc(i_idx_ff);
              i_cnt_ff <= 4'h1;
              i_st_ff <= dsp_pkg::DI_TX;
            end else begin
              i_sda_ff <= 1'b1;
              i_cnt_ff <= 4'h0;
              i_st_ff <= dsp_pkg::DI_RX;
            end
          end
        end
        dsp_pkg::DI_TX: begin
          if (scl_fall) begin
            if (i_cnt_ff == 4'h8) begin
              i_sda_ff <= 1'b1;
              i_st_ff <= dsp_pkg::DI_MACK;
            end else begin
              i_sda_ff <= i_tx_ff[7];
              i_tx_ff <= {i_tx_ff[6:0], 1'b0};
              i_cnt_ff <= i_cnt_ff + 4'h1;
            end
          end
        end
        dsp_pkg::DI_MACK: begin
          if (scl_rise) begin
            i_st_ff <= s_sda ? dsp_pkg::DI_IDLE : dsp_pkg::DI_ACK;
          end
        end
        default: begin
          i_st_ff <= dsp_pkg::DI_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // four-wire slave
  // ------------------------------------------------------------
  assign s_push = ~s_csn & scl_rise & (s_cnt_ff == 3'h7)
    & ~s_first_ff & ~s_rw_ff;
  assign s_load = ~s_csn & scl_fall & (s_cnt_ff == 3'h0)
    & ~s_first_ff & s_rw_ff;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_cnt_ff <= 3'h0;
      s_rx_ff <= 8'h00;
      s_tx_ff <= 8'h00;
      s_idx_ff <= 7'h00;
      s_rw_ff <= 1'b0;
      s_first_ff <= 1'b1;
      s_so_ff <= 1'b0;
      s_oe_n_ff <= 1'b1;
    end else if (s_csn) begin
      s_cnt_ff <= 3'h0;
      s_first_ff <= 1'b1;
      s_oe_n_ff <= 1'b1;
    end else begin
      s_oe_n_ff <= 1'b0;
      if (scl_rise) begin
        s_rx_ff <= {s_rx_ff[6:0], s_sda};
        s_cnt_ff <= s_cnt_ff + 3'h1;
        if (s_cnt_ff == 3'h7) begin
          s_first_ff <= 1'b0;
          if (s_first_ff) begin
            s_rw_ff <= s_rx_ff[6];
            s_idx_ff <= {s_rx_ff[5:0], s_sda};
          end else if (!s_rw_ff) begin
            s_idx_ff <= idx_inc(s_idx_ff);
          end
        end
      end
      if (scl_fall) begin
        if (s_load) begin
          s_so_ff <= rd_data[7];
          s_tx_ff <= {rd_data[6:0], 1'b0};
          s_idx_ff <= idx_inc(s_idx_ff);
        end else begin
          s_so_ff <= s_tx_ff[7];
          s_tx_ff <= {s_tx_ff[6:0], 1'b0};
        end
      end
    end
  end

  // ------------------------------------------------------------
  // write path and port disable
  // ------------------------------------------------------------
  // spi cannot stall, so a byte meeting a full buffer is lost
  assign f_valid = i_push | s_push;
  assign f_data = s_csn ? {i_idx_ff, i_rx_ff}
    : {s_idx_ff, s_rx_ff[6:0], s_sda};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ifdis_ff <= 1'b0;
    end else if (f_valid && f_ready && f_data[14:8] == `DSP_CTRL_IDX) begin
      ifdis_ff <= f_data[`DSP_IFDIS_BIT];
    end
  end

  dsp_fifo #(.W(15), .DEPTH(DEPTH)) u_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_valid(f_valid),
    .in_data(f_data),
    .in_ready(f_ready),
    .out_valid(wr_valid),
    .out_data({wr_idx, wr_data}),
    .out_ready(wr_ready)
  );

  assign rd_idx = s_csn ? i_idx_ff : s_idx_ff;
  assign rd_take = i_load | s_load;
  assign two_wire_port_disable = ifdis_ff;
  assign link.dev_clk_oe_n = i_scl_ff;
  assign link.dev_dat_oe_n = i_sda_ff;
  assign link.sdo_o = s_so_ff;
  assign link.sdo_oe_n = s_oe_n_ff;
endmodule : dsp_dev_end
`default_nettype wire

// ### hdl/dsp_host_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsp_defs.svh"
module dsp_host_end #(
  parameter int I2C_QTR = `DSP_I2C_QTR,
  parameter int SPI_HALF = `DSP_SPI_HALF
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // link pins
  dsp_link_if.host link,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_spi,
  input wire logic cmd_read,
  input wire logic cmd_sel,
  input wire dsp_pkg::dsp_idx_t cmd_idx,
  input wire logic [7:0] cmd_len,
  // data bytes
  output logic byte_req,
  input wire dsp_pkg::dsp_byte_t byte_wdata,
  output logic rd_valid,
  output dsp_pkg::dsp_byte_t rd_data,
  output logic done,
  output logic nack_err
);
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic s_scl, s_sda, s_sdo;
  logic [7:0] div_ff;
  logic tick;
  dsp_pkg::dsp_host_st_e st_ff;
  dsp_pkg::dsp_stage_e stg_ff;
  logic [1:0] ph_ff;
  logic [3:0] bit_ff;
  dsp_pkg::dsp_byte_t sh_ff;
  logic [7:0] left_ff;
  logic rd_ff, sel_ff, nack_ff, last;
  dsp_pkg::dsp_idx_t idx_ff;
  logic scl_ff, sda_ff, cs_n_ff, rdv_ff, done_ff, err_ff;
  logic i_end, s_end;

  assign s_scl = sync2_ff[0];
  assign s_sda = sync2_ff[1];
  assign s_sdo = sync2_ff[2];
  assign last = (left_ff == 8'h01);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_ff <= 3'h7;
      sync2_ff <= 3'h7;
    end else begin
      sync1_ff <= {link.sdo_line, link.dat_line, link.clk_line};
      sync2_ff <= sync1_ff;
    end
  end

  // bus clock divider keeps within the rated rates
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_ff <= 8'h00;
    end else if (st_ff == dsp_pkg::H_IDLE || tick) begin
      div_ff <= 8'h00;
    end else begin
      div_ff <= div_ff + 8'h01;
    end
  end
  assign tick = (st_ff == dsp_pkg::H_SPI) ? (div_ff == 8'(SPI_HALF - 1))
    : (div_ff == 8'(I2C_QTR - 1));

  assign i_end = tick & (st_ff == dsp_pkg::H_BYTE) & (ph_ff == 2'h3)
    & (bit_ff == 4'h8);
  assign s_end = tick & (st_ff == dsp_pkg::H_SPI) & (ph_ff == 2'h1)
    & (bit_ff == 4'h7);
  assign byte_req = (i_end & ~(nack_ff & ~stg_ff[4])
    & ((stg_ff == dsp_pkg::SG_IDX & ~rd_ff)
    | (stg_ff == dsp_pkg::SG_DATA & ~last)))
    | (s_end & ~rd_ff & ((stg_ff == dsp_pkg::SG_ADDRW) | ~last));
  assign cmd_ready = (st_ff == dsp_pkg::H_IDLE);

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= dsp_pkg::H_IDLE;
      stg_ff <= dsp_pkg::SG_ADDRW;
      ph_ff <= 2'h0;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      left_ff <= 8'h00;
      rd_ff <= 1'b0;
      sel_ff <= 1'b0;
      idx_ff <= 7'h00;
      nack_ff <= 1'b0;
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      cs_n_ff <= 1'b1;
      rdv_ff <= 1'b0;
      rd_data <= 8'h00;
      done_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      rdv_ff <= 1'b0;
      done_ff <= 1'b0;
      case (st_ff)
        dsp_pkg::H_IDLE: begin
          if (cmd_valid) begin
            rd_ff <= cmd_read;
            sel_ff <= cmd_sel;
            idx_ff <= cmd_idx;
            left_ff <= (cmd_len == 8'h00) ? 8'h01 : cmd_len;
            err_ff <= 1'b0;
            ph_ff <= 2'h0;
            bit_ff <= 4'h0;
            stg_ff <= dsp_pkg::SG_ADDRW;
            if (cmd_spi) begin
              sh_ff <= {cmd_read, cmd_idx};
              cs_n_ff <= 1'b0;
              st_ff <= dsp_pkg::H_SPI;
            end else begin
              sh_ff <= {`DSP_ADDR_HI, cmd_sel, `DSP_DIR_WR};
              st_ff <= dsp_pkg::H_START;
            end
          end
        end
        dsp_pkg::H_START, dsp_pkg::H_STOP: begin
          if (tick) begin
            ph_ff <= ph_ff + 2'h1;
            case (ph_ff)
              2'h0: sda_ff <= (st_ff == dsp_pkg::H_START);
              2'h1: scl_ff <= 1'b1;
              2'h2: sda_ff <= (st_ff == dsp_pkg::H_STOP);
              default: begin
                if (st_ff == dsp_pkg::H_START) begin
                  scl_ff <= 1'b0;
                  st_ff <= dsp_pkg::H_BYTE;
                end else begin
                  done_ff <= 1'b1;
                  st_ff <= dsp_pkg::H_IDLE;
                end
              end
            endcase
          end
        end
        dsp_pkg::H_BYTE: begin
          if (tick && !(ph_ff == 2'h2 && !s_scl)) begin
            ph_ff <= ph_ff + 2'h1;
            case (ph_ff)
              2'h0: begin
                if (bit_ff != 4'h8) begin
                  sda_ff <= (stg_ff == dsp_pkg::SG_RDATA) | sh_ff[7];
                end else begin
                  sda_ff <= (stg_ff != dsp_pkg::SG_RDATA) | last;
                end
              end
              2'h1: scl_ff <= 1'b1;
              2'h2: begin
                if (bit_ff != 4'h8) begin
                  sh_ff <= {sh_ff[6:0], s_sda};
                end else begin
                  nack_ff <= s_sda;
                end
              end
              default: begin
                scl_ff <= 1'b0;
                bit_ff <= (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
                if (bit_ff == 4'h8) begin
                  if (nack_ff && stg_ff != dsp_pkg::SG_RDATA) begin
                    err_ff <= 1'b1;
                    st_ff <= dsp_pkg::H_STOP;
                  end else begin
                    case (stg_ff)
                      dsp_pkg::SG_ADDRW: begin
                        stg_ff <= dsp_pkg::SG_IDX;
                        sh_ff <= {1'b0, idx_ff};
                      end
                      dsp_pkg::SG_IDX: begin
                        if (rd_ff) begin
                          stg_ff <= dsp_pkg::SG_ADDRR;
                          sh_ff <= {`DSP_ADDR_HI, sel_ff, `DSP_DIR_RD};
                          st_ff <= dsp_pkg::H_START;
                        end else begin
                          stg_ff <= dsp_pkg::SG_DATA;
                          sh_ff <= byte_wdata;
                        end
                      end
                      dsp_pkg::SG_ADDRR: begin
                        stg_ff <= dsp_pkg::SG_RDATA;
                      end
                      default: begin
                        if (stg_ff == dsp_pkg::SG_RDATA) begin
                          rdv_ff <= 1'b1;
                          rd_data <= sh_ff;
                        end
                        left_ff <= left_ff - 8'h01;
                        sh_ff <= byte_wdata;
                        if (last) begin
                          st_ff <= dsp_pkg::H_STOP;
                        end
                      end
                    endcase
                  end
                end
              end
            endcase
          end
        end
        dsp_pkg::H_SPI: begin
          if (tick) begin
            ph_ff <= ph_ff + 2'h1;
            if (ph_ff == 2'h0) begin
              scl_ff <= 1'b0;
              sda_ff <= sh_ff[7];
            end else if (ph_ff == 2'h1) begin
              scl_ff <= 1'b1;
              sh_ff <= {sh_ff[6:0], s_sdo};
              bit_ff <= (bit_ff == 4'h7) ? 4'h0 : bit_ff + 4'h1;
              ph_ff <= 2'h0;
              if (s_end) begin
                sh_ff <= rd_ff ? 8'hFF : byte_wdata;
                stg_ff <= dsp_pkg::SG_DATA;
                if (stg_ff == dsp_pkg::SG_DATA) begin
                  left_ff <= left_ff - 8'h01;
                  rdv_ff <= rd_ff;
                  rd_data <= {sh_ff[6:0], s_sdo};
                  ph_ff <= last ? 2'h2 : 2'h0;
                end
              end
            end else begin
              sda_ff <= 1'b1;
              cs_n_ff <= 1'b1;
              done_ff <= 1'b1;
              st_ff <= dsp_pkg::H_IDLE;
            end
          end
        end
        default: begin
          st_ff <= dsp_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign rd_valid = rdv_ff;
  assign done = done_ff;
  assign nack_err = err_ff;
  assign link.host_clk_oe_n = scl_ff;
  assign link.host_dat_oe_n = sda_ff;
  assign link.cs_n = cs_n_ff;
endmodule : dsp_host_end
`default_nettype wire

// ### tb/dsp_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dsp_link_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // link lines
  input wire logic clk_line,
  input wire logic dat_line,
  input wire logic dev_clk_oe_n,
  input wire logic dev_dat_oe_n,
  input wire logic cs_n,
  input wire logic sdo_o,
  input wire logic sdo_oe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_stop; clk_line && $rose(dat_line); endsequence
  sequence s_ack; !dev_dat_oe_n && clk_line; endsequence
  chk_sdo_float: assert property (cs_n [*5] |-> sdo_oe_n)
    else $error("sdo driven while idle");
  chk_spi_no_stretch: assert property (!cs_n |-> dev_clk_oe_n)
    else $error("clock held in spi");
  chk_spi_no_pull: assert property (!cs_n |-> dev_dat_oe_n)
    else $error("data pulled in spi");
  chk_dat_clk_low: assert property ($changed(dev_dat_oe_n) |-> !clk_line)
    else $error("data moved with clock high");
  chk_stretch_low: assert property ($fell(dev_clk_oe_n) |-> !clk_line)
    else $error("stretch began high");
  chk_ack_held: assert property (s_ack |=> !dev_dat_oe_n || !clk_line)
    else $error("ack dropped early");
  chk_stop_release: assert property (s_stop |=> dev_dat_oe_n [*4])
    else $error("data held after stop");
  // sdo may only move while the serial clock is low
  chk_sdo_fall: assert property ($changed(sdo_o) && !sdo_oe_n && !cs_n
    |-> !clk_line) else $error("sdo moved high");
endmodule : dsp_link_properties
`default_nettype wire

// ### tb/dual_serial_register_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module dual_serial_register_port_tb_top;
  logic core_clk = 1'b0, arst_n = 1'b0, wr_ready = 1'b0, hold = 1'b0;
  logic cmd_valid = 1'b0, cmd_spi = 1'b0, cmd_read = 1'b0, cmd_sel = 1'b0;
  logic cmd_ready, byte_req, rd_valid, done, nack_err, wr_valid, rd_take;
  logic two_wire_port_disable, req_q = 1'b0;
  logic [15:0] wr_q = 16'h0000;
  logic [7:0] cmd_len = 8'h00;
  logic [14:0] exp_w, wq [$];
  logic [31:0] seed = 32'h00011B51;
  dsp_pkg::dsp_idx_t cmd_idx = 7'h00, wr_idx, rd_idx;
  dsp_pkg::dsp_byte_t byte_wdata = 8'h00, h_rd, wr_data, exp_r, rq [$];
  dsp_pkg::dsp_byte_t mem [128] = '{default: 8'h00};
  dsp_pkg::dsp_byte_t refm [128] = '{default: 8'h00};
  int fail_count = 0, num_checks = 0, cyc = 0, takes = 0;
  dsp_link_if i_dsp_link_if ();
  dsp_dev_end i_dsp_dev_end (.link(i_dsp_link_if.dev),
    .rd_data(mem[rd_idx]), .*);
  dsp_host_end #(.I2C_QTR(4), .SPI_HALF(6)) i_dsp_host_end (
    .link(i_dsp_link_if.host), .rd_data(h_rd), .*);
  dsp_link_properties i_dsp_link_properties (.core_clk, .arst_n,
    .clk_line(i_dsp_link_if.clk_line), .dat_line(i_dsp_link_if.dat_line),
    .dev_clk_oe_n(i_dsp_link_if.dev_clk_oe_n), .cs_n(i_dsp_link_if.cs_n),
    .dev_dat_oe_n(i_dsp_link_if.dev_dat_oe_n), .sdo_o(i_dsp_link_if.sdo_o),
    .sdo_oe_n(i_dsp_link_if.sdo_oe_n));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic xfer(input logic spi, rd, sel, input dsp_pkg::dsp_idx_t idx,
      input int n, input dsp_pkg::dsp_byte_t b, input logic ok);
    int t;
    dsp_pkg::dsp_idx_t j;
    byte_wdata = b;
    takes = 0;
    for (int k = 0; k < n && ok; k++) begin
      j = idx + 7'(k);
      if (rd) rq.push_back(refm[j]);
      else wq.push_back({j, b + 8'(k)});
      if (!rd) refm[j] = b + 8'(k);
    end
    {cmd_spi, cmd_read, cmd_sel, cmd_idx, cmd_len} = {spi, rd, sel, idx, 8'(n)};
    cmd_valid = 1'b1;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    t = 0;
    do @(negedge core_clk); while (!done && ++t < 8000);
    `CHK(done, 1'b1)
    `CHK(nack_err, !ok)
    `CHK(cmd_ready, 1'b1)
    while ((wq.size() + rq.size()) != 0 && t++ < 9000) @(negedge core_clk);
    `CHK(wq.size() + rq.size(), 0)
    `CHK(takes, rd ? n : 0)
    $display("test done spi %0b read %0b bytes %0d", spi, rd, n);
  endtask : xfer
  always #2.5 core_clk = ~core_clk;
  always @(negedge core_clk) begin
    seed <= lfsr(seed);
    wr_ready <= !hold && seed[2];
    // inputs move only on the falling edge, half a cycle after the host sampled them
    if (req_q) byte_wdata <= byte_wdata + 8'h01;
    req_q <= byte_req;
    if (wr_q[15]) mem[wr_q[14:8]] <= wr_q[7:0];
  end
  always @(posedge core_clk) begin
    wr_q <= {wr_valid && wr_ready, wr_idx, wr_data};
    if (rd_take) takes++;
    if (wr_valid && wr_ready) begin
      exp_w = wq.pop_front();
      `CHK({wr_idx, wr_data}, exp_w)
    end
    if (rd_valid) begin
      exp_r = rq.pop_front();
      `CHK(h_rd, exp_r)
    end
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    i_dsp_link_if.addr_strap = 1'b0;
    repeat (8) @(negedge core_clk);
    arst_n = 1'b1;
    for (int s = 0; s < 2; s++) begin
      i_dsp_link_if.addr_strap = s[0];
      xfer(1'b0, 1'b0, s[0], 7'h20, 1, seed[7:0], 1'b1);
      xfer(1'b0, 1'b0, !s[0], 7'h21, 1, 8'h00, 1'b0);
    end
    // ready withheld so the buffer fills and the clock gets stretched
    hold = 1'b1;
    fork
      xfer(1'b0, 1'b0, 1'b1, 7'h7C, 12, seed[7:0], 1'b1);
      begin repeat (2500) @(negedge core_clk); hold = 1'b0; end
    join
    xfer(1'b0, 1'b1, 1'b1, 7'h7C, 12, 8'h00, 1'b1);
    for (int m = 0; m < 4; m++)
      xfer(1'b1, m[0], 1'b1, 7'h10, m + 1, seed[7:0], 1'b1);
    xfer(1'b0, 1'b0, 1'b1, 7'h6A, 1, 8'h10, 1'b1);
    `CHK(two_wire_port_disable, 1'b1)
    xfer(1'b0, 1'b0, 1'b1, 7'h30, 1, 8'h00, 1'b0);
    xfer(1'b1, 1'b1, 1'b1, 7'h6A, 1, 8'h00, 1'b1);
    tally_and_finish();
  end
endmodule : dual_serial_register_port_tb_top
`default_nettype wire
